/* design/i2s_port_cfg.svh */
// offsets, field positions, sample widths and timing counts of the audio port
`ifndef I2S_PORT_CFG_SVH
`define I2S_PORT_CFG_SVH

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PLAY_L 8'h08
`define REG_PLAY_R 8'h0C
`define REG_REC_L 8'h10
`define REG_REC_R 8'h14

`define ST_REC_READY 0
`define ST_PLAY_TAKEN 1
`define ST_RUNNING 2
`define ST_LRCLK 3
`define ST_TRIM_SLOW 4
`define ST_TRIM_FAST 5

`define RATIO_48 250
`define RATIO_441 272
`define WIDTH_16 8'h10
`define WIDTH_24 8'h18
`define MCLK_HALF_CYCLES 2'h2
`define CLK_PERIOD_NS 100
`define SOF_PERIOD_NS 1000000
`define SOF_TOL 1

`endif

/* design/audio_port_pkg.sv */
// types shared by the audio port modules
package audio_port_pkg;

   typedef enum logic [1:0] {MODE_DUPLEX, MODE_PLAY, MODE_REC} stream_mode_t;

   typedef enum logic {PORT_IDLE, PORT_RUN} port_state_t;

   typedef struct packed {
      logic sync;
      logic res24;
      logic [1:0] mode;
      logic rate441;
      logic en;
   } ctrl_t;

endpackage

/* design/ahb_reg_port.sv */
// ahb-lite slave front end: write strobe in data phase, reads take one wait
`timescale 1ns/1ps
module ahb_reg_port
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic wr_stb,
   output logic rd_stb,
   output logic [7:0] reg_addr
);

   typedef struct packed {
      logic wr_pend;
      logic rd_pend;
      logic [7:0] addr;
   } slave_t;

   slave_t s;
   slave_t next_s;

   always_comb
   begin
      next_s = s;
      if (hready)
      begin
         next_s.wr_pend = 1'b0;
         next_s.rd_pend = 1'b0;
         if (hsel && htrans[1])
         begin
            next_s.wr_pend = hwrite;
            next_s.rd_pend = !hwrite;
            next_s.addr = haddr[7:0];
         end
      end
      else
      begin
         // the single wait cycle of a read is spent here
         next_s.rd_pend = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s <= '0;
      else
         s <= next_s;
   end

   // read data is registered, so each read costs one wait state
   assign hreadyout = !s.rd_pend;
   assign hresp = 1'b0;
   assign wr_stb = s.wr_pend;
   assign rd_stb = s.rd_pend;
   assign reg_addr = s.addr;

endmodule

/* design/i2s_master_audio_port.sv */
// serial audio master port: clocks, playback shifter, record capture, trim
`timescale 1ns/1ps
`include "i2s_port_cfg.svh"

// Operation
// - The port drives a master clock output that runs without stopping.
// - The frame clock level tells which channel is on the data lines.
// - The frame clock makes one full period per stereo sample pair.
// - Master and frame clock share one source, frame an integer of master.
// - Data on both lines is valid at and sampled on the bit clock rise.
// - The port is the bus master and drives frame and bit clocks itself.
// - Playback samples leave serially on the playback data output.
// - Only the 44.1 kHz and 48 kHz sample rates can be selected.
// - Playback and record together always share one sample rate.
// - The frame is 250 master periods at 48 kHz and 272 at 44.1 kHz.
// - Exactly one mode: duplex 16 bit, play only or record only 16/24.
// - Each mode can run with synchronous or asynchronous endpoint timing.
// - In synchronous mode the clocks are trimmed to track frame markers.
// - In asynchronous mode the clocks are left untrimmed.
module i2s_master_audio_port
   import audio_port_pkg::*;
#(
   parameter int unsigned SOF_CYCLES = `SOF_PERIOD_NS / `CLK_PERIOD_NS
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic sof_pulse,
   output logic mclk,
   output logic sclk,
   output logic lrclk,
   output logic playback_data_out,
   input wire logic record_data_in
);

   typedef struct packed {
      ctrl_t ctrl;
      ctrl_t act;
      port_state_t pst;
      logic [1:0] div;
      logic sclk;
      logic [7:0] pos;
      logic lr;
      logic sdo;
      logic [23:0] play_l;
      logic [23:0] play_r;
      logic [23:0] tx_l;
      logic [23:0] tx_r;
      logic [23:0] rx;
      logic [23:0] rec_l;
      logic [23:0] rec_r;
      logic rec_ready;
      logic play_taken;
      logic trim_slow;
      logic trim_fast;
      logic slow_pend;
      logic fast_pend;
      logic [15:0] sof_cnt;
      logic sof_seen;
      logic s1;
      logic s2;
      logic [31:0] rdata;
   } core_t;

   core_t s;
   core_t next_s;
   logic wr_stb;
   logic rd_stb;
   logic [7:0] reg_addr;

   ahb_reg_port u_bus
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .reg_addr(reg_addr)
   );

   always_comb
   begin
      logic [7:0] half_len;
      logic [7:0] wid;
      logic [7:0] np;
      logic [1:0] seg_len;
      logic [4:0] ix;
      logic [23:0] word;
      logic tick;
      logic play_en;
      logic rec_en;
      logic load;
      half_len = 8'h00;
      wid = 8'h00;
      np = 8'h00;
      seg_len = 2'h0;
      ix = 5'h00;
      word = 24'h000000;
      tick = 1'b0;
      play_en = 1'b0;
      rec_en = 1'b0;
      load = 1'b0;
      next_s = s;

      // bus side; hardware sets below come later so a set beats a clear
      if (wr_stb)
      begin
         unique case (reg_addr)
            `REG_CTRL: next_s.ctrl = ctrl_t'(hwdata[5:0]);
            `REG_STATUS:
            begin
               if (hwdata[`ST_REC_READY])
                  next_s.rec_ready = 1'b0;
               if (hwdata[`ST_PLAY_TAKEN])
                  next_s.play_taken = 1'b0;
               if (hwdata[`ST_TRIM_SLOW])
                  next_s.trim_slow = 1'b0;
               if (hwdata[`ST_TRIM_FAST])
                  next_s.trim_fast = 1'b0;
            end
            `REG_PLAY_L: next_s.play_l = hwdata[23:0];
            `REG_PLAY_R: next_s.play_r = hwdata[23:0];
            default: ;
         endcase
      end
      if (rd_stb)
      begin
         unique case (reg_addr)
            `REG_CTRL: next_s.rdata = {26'h0000000, s.ctrl};
            `REG_STATUS: next_s.rdata = {26'h0000000, s.trim_fast,
               s.trim_slow, s.lr, s.pst == PORT_RUN, s.play_taken,
               s.rec_ready};
            `REG_PLAY_L: next_s.rdata = {8'h00, s.play_l};
            `REG_PLAY_R: next_s.rdata = {8'h00, s.play_r};
            `REG_REC_L: next_s.rdata = {8'h00, s.rec_l};
            `REG_REC_R: next_s.rdata = {8'h00, s.rec_r};
            default: next_s.rdata = 32'h00000000;
         endcase
      end

      next_s.s1 = record_data_in;
      next_s.s2 = s.s1;

      half_len = s.act.rate441 ? 8'(`RATIO_441 / 2) : 8'(`RATIO_48 / 2);
      wid = s.act.res24 ? `WIDTH_24 : `WIDTH_16;
      play_en = s.act.mode != MODE_REC;
      rec_en = s.act.mode != MODE_PLAY;

      // trim only stretches or shortens the low half, so record capture stays safe
      seg_len = `MCLK_HALF_CYCLES;
      if (!s.sclk && s.slow_pend)
         seg_len = `MCLK_HALF_CYCLES + 2'h1;
      else if (!s.sclk && s.fast_pend)
         seg_len = `MCLK_HALF_CYCLES - 2'h1;
      // one divider feeds every audio clock
      tick = s.div >= seg_len - 2'h1;
      next_s.div = tick ? 2'h0 : s.div + 2'h1;
      if (tick)
      begin
         next_s.sclk = !s.sclk;
         if (!s.sclk)
         begin
            next_s.slow_pend = 1'b0;
            next_s.fast_pend = 1'b0;
         end
      end

      if (tick && s.sclk)
      begin
         if (s.pst == PORT_RUN)
         begin
            // bit taken as it stood at the rising edge
            if (rec_en && s.pos >= 8'h01 && s.pos <= wid)
            begin
               ix = 5'(wid - s.pos);
               next_s.rx[ix] = s.s2;
            end
            if (s.pos == half_len - 8'h01)
            begin
               if (rec_en && s.lr)
               begin
                  next_s.rec_r = s.rx;
                  next_s.rec_ready = 1'b1;
               end
               else if (rec_en)
                  next_s.rec_l = s.rx;
               next_s.rx = 24'h000000;
               next_s.pos = 8'h00;
               // one frame clock period per sample pair
               next_s.lr = !s.lr;
               if (s.lr)
               begin
                  if (s.ctrl.en)
                     load = 1'b1;
                  else
                  begin
                     next_s.pst = PORT_IDLE;
                     next_s.lr = 1'b0;
                  end
               end
            end
            else
               next_s.pos = s.pos + 8'h01;
            // msb one bit after the frame edge, left on low
            np = next_s.pos;
            word = next_s.lr ? s.tx_r : s.tx_l;
            next_s.sdo = 1'b0;
            // playback bit shifted out on the falling edge
            if (play_en && next_s.pst == PORT_RUN && np >= 8'h01 &&
               np <= wid)
            begin
               ix = 5'(wid - np);
               next_s.sdo = word[ix];
            end
         end
         else if (s.ctrl.en)
         begin
            load = 1'b1;
            next_s.pst = PORT_RUN;
            next_s.pos = 8'h00;
            next_s.lr = 1'b0;
            next_s.sdo = 1'b0;
         end
      end

      // config changes only at a frame boundary, so one mode holds per frame
      if (load)
      begin
         // rate bit picks one of two divisors
         next_s.act = s.ctrl;
         next_s.act.rate441 = s.ctrl.rate441;
         // illegal mode code falls back to duplex
         unique case (s.ctrl.mode)
            MODE_PLAY: next_s.act.mode = MODE_PLAY;
            MODE_REC: next_s.act.mode = MODE_REC;
            default:
            begin
               next_s.act.mode = MODE_DUPLEX;
               next_s.act.res24 = 1'b0;
            end
         endcase
         next_s.tx_l = s.play_l;
         next_s.tx_r = s.play_r;
         next_s.play_taken = 1'b1;
      end

      if (s.sof_cnt != 16'hFFFF)
         next_s.sof_cnt = s.sof_cnt + 16'h0001;
      if (sof_pulse)
      begin
         next_s.sof_cnt = 16'h0000;
         next_s.sof_seen = 1'b1;
         if (s.act.sync && s.sof_seen && s.pst == PORT_RUN)
         begin
            // longer marker gap means the audio clocks run fast
            if (s.sof_cnt >= 16'(SOF_CYCLES + `SOF_TOL))
            begin
               next_s.slow_pend = 1'b1;
               next_s.trim_slow = 1'b1;
            end
            else if (s.sof_cnt + 16'h0001 < 16'(SOF_CYCLES - `SOF_TOL))
            begin
               next_s.fast_pend = 1'b1;
               next_s.trim_fast = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s <= '0;
      else
         s <= next_s;
   end

   // frame and bit clock are outputs only
   assign mclk = s.sclk;
   assign sclk = s.sclk;
   // frame clock level names the channel
   assign lrclk = s.lr;
   assign playback_data_out = s.sdo;
   assign hrdata = s.rdata;

endmodule

/* verif/audio_port_checker.sv */
// checker on the audio port's bus and serial clock pins
`timescale 1ns/1ps
module audio_port_checker
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic mclk,
   input wire logic sclk,
   input wire logic lrclk,
   input wire logic playback_data_out
);
   logic [7:0] rises;
   wire req = hsel & htrans[1] & hready;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // bit clock rises per half frame, independent of any trim
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rises <= 8'h00;
      else if ($changed(lrclk))
         rises <= 8'h00;
      else if ($rose(sclk))
         rises <= rises + 8'h01;
   end
   property p_one_src;
      sclk == mclk && (!$changed(lrclk) || $fell(mclk));
   endproperty
   a_one_src: assert property (p_one_src) else $error("clocks split");
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("bad response");
   property p_high; $rose(mclk) |=> mclk ##1 !mclk; endproperty
   a_high: assert property (p_high) else $error("mclk high half");
   property p_low; $fell(mclk) |-> ##[1:3] mclk; endproperty
   a_low: assert property (p_low) else $error("mclk stalled");
   property p_rd; req && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
   a_rd: assert property (p_rd) else $error("read wait wrong");
   property p_wr; req && hwrite |=> hreadyout; endproperty
   a_wr: assert property (p_wr) else $error("write waited");
   property p_lr; $changed(lrclk) |-> !sclk; endproperty
   a_lr: assert property (p_lr) else $error("lrclk off edge");
   property p_sd; $changed(playback_data_out) |-> !sclk; endproperty
   a_sd: assert property (p_sd) else $error("data off edge");
   property p_half;
      $fell(lrclk) |-> rises == 8'h7D || rises == 8'h88;
   endproperty
   a_half: assert property (p_half) else $error("half frame");
   cover property (req && !hwrite);
   cover property ($fell(lrclk));
   cover property ($fell(mclk) ##1 !mclk ##1 !mclk ##1 !mclk);
endmodule

bind i2s_master_audio_port audio_port_checker chk_i
(
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .mclk(mclk), .sclk(sclk), .lrclk(lrclk),
   .playback_data_out(playback_data_out)
);

/* verif/codec_model.sv */
// behavioural slave converter: record source and playback capture
`timescale 1ns/1ps
module codec_model
(
   input wire logic sclk,
   input wire logic lrclk,
   input wire logic playback_data_out,
   input wire logic [23:0] rec_l,
   input wire logic [23:0] rec_r,
   output logic record_data_in,
   output logic [23:0] cap_l,
   output logic [23:0] cap_r
);
   int pos = 0;
   logic last_lr = 1'b0;
   logic [23:0] smp;
   logic [23:0] sh;
   // frame and bit clock are only read
   // msb one bit after the frame edge
   always @(negedge sclk)
   begin
      #1;
      pos = (lrclk != last_lr) ? 0 : pos + 1;
      last_lr = lrclk;
      smp = lrclk ? rec_r : rec_l;
      // past the lsb the line floats, so it flips
      if (pos >= 1 && pos <= 24)
         record_data_in = smp[24 - pos];
      else
         record_data_in = ~record_data_in;
   end
   // taken on the bit clock rise
   // words published whole at the last slot, so reads never see a half shift
   always @(posedge sclk)
      if (pos >= 1 && pos <= 24)
      begin
         sh = {sh[22:0], playback_data_out};
         if (pos == 24 && lrclk)
            cap_r = sh;
         else if (pos == 24)
            cap_l = sh;
      end
endmodule

/* verif/tb.sv */
// self-checking bench for the serial audio master port
`timescale 1ns/1ps
`include "i2s_port_cfg.svh"
module tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic sof_pulse = 1'b0;
   logic [23:0] rec_l = 24'h9ABCDE;
   logic [23:0] rec_r = 24'h3579BD;
   logic [31:0] hrdata, q;
   logic hreadyout, hresp, mclk, sclk, lrclk, sdo, sdi;
   logic [23:0] cap_l, cap_r;
   int fails = 0;
   int cmp_count = 0;
   time t0;
   always #50 hclk = ~hclk;
   i2s_master_audio_port #(.SOF_CYCLES(200)) uut
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .sof_pulse(sof_pulse), .mclk(mclk), .sclk(sclk),
      .lrclk(lrclk), .playback_data_out(sdo), .record_data_in(sdi)
   );
   codec_model model
   (
      .sclk(sclk), .lrclk(lrclk), .playback_data_out(sdo), .rec_l(rec_l),
      .rec_r(rec_r), .record_data_in(sdi), .cap_l(cap_l), .cap_r(cap_r)
   );
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // hready is judged mid-cycle so no edge race decides it
   task automatic wait_rdy;
      logic rdy;
      do
      begin
         @(negedge hclk);
         rdy = hreadyout;
         q = hrdata;
         @(posedge hclk);
      end
      while (rdy !== 1'b1);
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask
   task automatic rd(input string nm, input logic [31:0] a, e);
      ahb(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask
   task automatic sof(input int gap);
      repeat (3)
      begin
         sof_pulse <= 1'b1;
         @(posedge hclk);
         sof_pulse <= 1'b0;
         repeat (gap - 1) @(posedge hclk);
      end
   endtask
   // status reads just after a frame start, so the lrclk bit is 0
   task automatic frame_start;
      @(negedge lrclk);
      @(posedge hclk);
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic run(input string nm, input logic [31:0] c, pl, pr, el,
      er, cl, cr, input int ratio);
      ahb(1'b1, `REG_PLAY_L, pl);
      ahb(1'b1, `REG_PLAY_R, pr);
      ahb(1'b1, `REG_CTRL, c);
      repeat (2) @(negedge lrclk);
      t0 = $time;
      repeat (8) @(posedge hclk);
      rd("rec_l", `REG_REC_L, el);
      rd("rec_r", `REG_REC_R, er);
      rd("status", `REG_STATUS, 32'h07);
      chk("play_l", cl, {8'h00, cap_l});
      chk("play_r", cr, {8'h00, cap_r});
      frame_start();
      chk("frame", 32'(ratio * 4), 32'($time - t0 - 100) / 32'h64);
      $display("test done: %s", nm);
   endtask
   initial
   begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd("ctrl", `REG_CTRL, 32'h0);
      rd("status", `REG_STATUS, 32'h0);
      ahb(1'b1, `REG_REC_L, 32'h1234);
      rd("rec_l", `REG_REC_L, 32'h0);
      ahb(1'b1, 32'h20, 32'hFFFF);
      rd("hole", 32'h20, 32'h0);
      $display("test done: reset");
      run("duplex", 32'h11, 32'hFFA5C3, 32'h5A3C, 32'h9ABC, 32'h3579,
         32'hA5C300, 32'h5A3C00, `RATIO_48);
      run("play", 32'h17, 32'hC3A581, 32'h123456, 32'h9ABC, 32'h3579,
         32'hC3A581, 32'h123456, `RATIO_441);
      rec_l <= 24'hC3A5F0;
      rec_r <= 24'h0F5A3C;
      run("record", 32'h19, 32'hC3A581, 32'h123456, 32'hC3A5F0,
         32'h0F5A3C, 32'h0, 32'h0, `RATIO_48);
      run("code3", 32'h0D, 32'hC3A581, 32'h123456, 32'hC3A5, 32'h0F5A,
         32'hA58100, 32'h345600, `RATIO_48);
      sof(150);
      frame_start();
      rd("async", `REG_STATUS, 32'h07);
      ahb(1'b1, `REG_CTRL, 32'h21);
      repeat (2) @(negedge lrclk);
      @(posedge hclk);
      sof(150);
      sof(250);
      frame_start();
      rd("sync", `REG_STATUS, 32'h37);
      ahb(1'b1, `REG_STATUS, 32'h33);
      rd("clear", `REG_STATUS, 32'h04);
      $display("test done: trim");
      ahb(1'b1, `REG_CTRL, 32'h0);
      @(negedge lrclk);
      repeat (600) @(posedge hclk);
      rd("stopped", `REG_STATUS, 32'h01);
      $display("test done: stop");
      complete_run();
   end
   initial
   begin
      repeat (40000) @(posedge hclk);
      fails++;
      complete_run();
   end
endmodule
